// ### include/boost_fault_pkg.sv
// Shared constants and carrier types for the boost setpoint and fault registers.
// Assumes a single 125 MHz clock and a byte-wide register port.
package boost_fault_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned GOOD_DELAY_US = 2000;
   localparam int unsigned SWITCH_SS_MS = 250;
   localparam int unsigned GOOD_DELAY_CYC = GOOD_DELAY_US * CLK_MHZ;
   localparam int unsigned SWITCH_SS_CYC = SWITCH_SS_MS * 1000 * CLK_MHZ;
   localparam int GATE_CNT_W = 25;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] ADDR_SETPOINT = 8'h0c;
   localparam logic [7:0] ADDR_SUMMARY = 8'h0d;
   localparam logic [7:0] ADDR_OVERLOAD = 8'h0e;
   localparam logic [7:0] ADDR_GOOD = 8'h0f;
   localparam logic [7:0] ADDR_CLEAR = 8'h11;

   localparam logic [7:0] SETPOINT_RST = 8'h00;
   localparam logic [7:0] SUMMARY_RST = 8'h00;
   localparam logic [7:0] OVERLOAD_RST = 8'h00;
   localparam logic [7:0] GOOD_RST = 8'h11;
   localparam logic [7:0] CLEAR_RST = 8'h00;
   localparam logic [7:0] CLEAR_CMD = 8'h01;
   localparam logic [7:0] CLEAR_ARMED = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   localparam int LOCK_BIT = 7;
   localparam int CODE_MSB = 5;
   localparam logic [5:0] CODE_ZERO = 6'h00;

   // Summary fields
   localparam int SUM_CODE_HI = 7;
   localparam int SUM_CODE_LO = 6;
   localparam int SUM_GOOD = 5;
   localparam int SUM_OVL = 4;
   localparam int SUM_HOT = 3;
   localparam int SUM_IN_OC = 1;
   localparam int SUM_IN_OV = 0;

   localparam logic [1:0] BFLT_NONE = 2'h0;
   localparam logic [1:0] BFLT_OVERVOLT = 2'h1;
   localparam logic [1:0] BFLT_DIODE = 2'h2;
   localparam logic [1:0] BFLT_SINK = 2'h3;

   // Rail bit positions, shared by overload, good, enable and run vectors
   localparam int RAIL_BOOST = 7;
   localparam int RAIL_ADJ = 6;
   localparam int RAIL_SWITCH = 0;
   localparam logic [7:0] CORE_MASK = 8'h1c;
   localparam logic [7:0] DEFAULT_MASK = 8'h3c;
   localparam logic [7:0] SW_EN_MASK = 8'hc1;
   localparam logic [7:0] ISOLATE_MASK = 8'h81;

   // Boost target voltage in millivolts
   localparam logic [15:0] BOOST_CODE1_MV = 16'h30d4;
   localparam logic [15:0] BOOST_STEP_MV = 16'h0064;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

   typedef struct packed {
      logic [7:0] rail_overload;
      logic [7:0] rail_good_fail;
      logic boost_overvolt;
      logic boost_diode_open;
      logic boost_sink_short;
      logic die_hot;
      logic input_overcurrent;
      logic input_overvoltage;
   } fault_event_type;

   typedef struct packed {
      logic [GATE_CNT_W-1:0] count;
      logic checking;
   } gate_state_type;

   typedef struct packed {
      logic [7:0] setpoint;
      logic [7:0] clear;
      logic [7:0] summary;
      logic [7:0] overload;
      logic [7:0] good;
      logic [7:0] trip;
      logic core_trip;
      logic power_on_q;
      logic [7:0] enable_q;
      logic [7:0] run;
      logic [7:0] restart;
      logic alert;
      logic [7:0] rdata;
      logic [15:0] target_mv;
   } top_state_type;

endpackage

// ### src/rail_fault_gate.sv
// Per-rail fault gate: arms overload and output-good detection for one rail.
// Assumes all inputs synchronous to clk; delay counts start once soft-start is done.
module rail_fault_gate
   import boost_fault_pkg::*;
#(
   parameter int unsigned DELAY_CYCLES = GOOD_DELAY_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic armed,
   input wire logic soft_start_done,
   input wire logic good_fail_raw,
   input wire logic overload_raw,
   output logic good_fault,
   output logic overload_fault
);

   localparam logic [GATE_CNT_W-1:0] LAST = GATE_CNT_W'(DELAY_CYCLES - 1);

   gate_state_type state_reg;
   gate_state_type state_next;

   always_comb begin
      state_next = state_reg;
      if (!(armed && soft_start_done)) begin
         state_next.count = '0;
         state_next.checking = 1'b0;
      end else if (!state_reg.checking) begin
         if (state_reg.count == LAST) begin
            state_next.checking = 1'b1;
         end else begin
            state_next.count = state_reg.count + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Output sag during soft-start is normal, so it is ignored until the delay ends
   assign good_fault = armed && state_reg.checking && good_fail_raw;
   assign overload_fault = armed && overload_raw;

endmodule

// ### src/boost_setpoint_and_fault_regs.sv
// Boost setpoint with write-once lock, fault summary/overload/good registers,
// fault alert and fault recovery sequencing.
// Assumes fault events and enables arrive synchronous to clk from the analog side.
//
// Functional notes
// - Boost code 01h means 12.5 V, each step 100 mV; code 00h invalid.
// - First nonzero code write sets lock bit 7.
// - Locked: code writes ignored, reads still work; only reset clears lock.
// - Boost runs only with enable bit set and nonzero setpoint.
// - Enable low or zero setpoint: boost off, no alert.
// - Boost fault detection armed only with enable and valid setpoint.
// - Summary: code 7:6, good 5, overload 4, hot 3, in-OC 1, in-OV 0.
// - Boost code: 00 none, 01 overvoltage, 10 diode/feedback, 11 sink short.
// - Any rail output-good fault sets the good fault flag.
// - Good bits 4 and 0 read one after power-up (11h); faulty rail bit cleared.
// - Overload sets summary flag and that rail's overload bit.
// - Die-hot warning sets the hot flag.
// - Input overcurrent and overvoltage events set their flags.
// - Core rail fault: alert low, all rails off; good checks after +2 ms.
// - Core detection armed only when clear register is 00h and power-on high.
// - Power-on rise clears faults, releases alert, restarts default rails.
// - After reset, default rails start only while power-on is high.
// - Switch good, boost faults: alert low, only that rail turned off.
// - Host writes 01h then 00h to clear; faults clear and detection rearms.
// - Per-rail arming needs clear 00h, enable set, valid setpoint where needed.
// - Enable rising edge restarts rail, clears faults, releases alert.
// - Clear register at 11h; value 01h clears all fault registers.
module boost_setpoint_and_fault_regs
   import boost_fault_pkg::*;
#(
   parameter int unsigned GOOD_DELAY_CYCLES = GOOD_DELAY_CYC,
   parameter int unsigned SWITCH_DELAY_CYCLES = SWITCH_SS_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire reg_req_type bus_req,
   output logic [7:0] bus_rdata,
   input wire logic default_rails_power_on,
   input wire logic [7:0] rail_enable,
   input wire logic adj_setpoint_valid,
   input wire logic boost_current_mode,
   input wire logic [7:0] soft_start_done,
   input wire fault_event_type fault_event,
   input wire logic fault_alert_n_in,
   output logic fault_alert_n_out,
   output logic fault_alert_oe_b,
   output logic [7:0] rail_run,
   output logic [7:0] rail_restart,
   output logic [15:0] boost_target_mv
);

   top_state_type state_reg;
   top_state_type state_next;

   logic clear_ok;
   logic [7:0] eff_en;
   logic [7:0] valid_sp;
   logic [7:0] armed;
   logic [7:0] rise;
   logic [7:0] good_ev;
   logic [7:0] ovl_ev;
   logic [7:0] ss_done;
   logic boost_valid;

   // ************************************************************
   // Arming and per-rail gates
   // ************************************************************
   assign boost_valid = state_reg.setpoint[CODE_MSB:0] != CODE_ZERO;
   assign clear_ok = state_reg.clear == CLEAR_ARMED;

   always_comb begin
      eff_en = (rail_enable & SW_EN_MASK) | (default_rails_power_on ? DEFAULT_MASK : BYTE_ZERO);
      valid_sp = 8'hff;
      valid_sp[RAIL_BOOST] = boost_valid;
      valid_sp[RAIL_ADJ] = adj_setpoint_valid;
      armed = clear_ok ? (eff_en & valid_sp) : BYTE_ZERO;
      rise = eff_en & ~state_reg.enable_q;
      ss_done = soft_start_done;
      // The switch output-good is judged only once its fixed soft-start window has ended; its overload is judged at once
      ss_done[RAIL_SWITCH] = 1'b1;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_rail
         rail_fault_gate #(
            .DELAY_CYCLES(gi == RAIL_SWITCH ? SWITCH_DELAY_CYCLES : GOOD_DELAY_CYCLES)
         ) u_gate (
            .clk(clk),
            .rst_b(rst_b),
            .armed(armed[gi]),
            .soft_start_done(ss_done[gi]),
            .good_fail_raw(fault_event.rail_good_fail[gi]),
            .overload_raw(fault_event.rail_overload[gi]),
            .good_fault(good_ev[gi]),
            .overload_fault(ovl_ev[gi])
         );
      end
   endgenerate

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic clear_all;
      logic [1:0] bcode;
      logic [1:0] bnew;
      logic [7:0] sum;
      logic [7:0] iso_trip;
      clear_all = 1'b0;
      bcode = BFLT_NONE;
      bnew = BFLT_NONE;
      sum = BYTE_ZERO;
      iso_trip = BYTE_ZERO;
      state_next = state_reg;
      state_next.power_on_q = default_rails_power_on;
      state_next.enable_q = eff_en;
      state_next.rdata = BYTE_ZERO;

      // Register writes
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            ADDR_SETPOINT: begin
               if (!state_reg.setpoint[LOCK_BIT]) begin
                  state_next.setpoint[CODE_MSB:0] = bus_req.wdata[CODE_MSB:0];
                  if (bus_req.wdata[CODE_MSB:0] != CODE_ZERO) begin
                     state_next.setpoint[LOCK_BIT] = 1'b1;
                  end
               end
            end
            ADDR_CLEAR: state_next.clear = bus_req.wdata;
            default: ;
         endcase
      end

      // Register reads: data stand one cycle after the strobe
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            ADDR_SETPOINT: state_next.rdata = state_reg.setpoint;
            ADDR_SUMMARY: state_next.rdata = state_reg.summary;
            ADDR_OVERLOAD: state_next.rdata = state_reg.overload;
            ADDR_GOOD: state_next.rdata = state_reg.good;
            ADDR_CLEAR: state_next.rdata = state_reg.clear;
            default: state_next.rdata = BYTE_ZERO;
         endcase
      end

      // Clearing first, so that a same-cycle event still lands afterwards
      clear_all = (state_reg.clear == CLEAR_CMD) || (rise != BYTE_ZERO);
      if (clear_all) begin
         state_next.summary = SUMMARY_RST;
         state_next.overload = OVERLOAD_RST;
         state_next.good = GOOD_RST;
         state_next.trip = BYTE_ZERO;
      end
      if ((rise & DEFAULT_MASK) != BYTE_ZERO) begin
         state_next.core_trip = 1'b0;
      end
      state_next.trip = state_next.trip & ~rise;

      // Boost fault code, only while boost detection is armed
      if (armed[RAIL_BOOST]) begin
         if (fault_event.boost_sink_short && boost_current_mode) begin
            bnew = BFLT_SINK;
         end else if (fault_event.boost_diode_open) begin
            bnew = BFLT_DIODE;
         end else if (fault_event.boost_overvolt && boost_current_mode) begin
            bnew = BFLT_OVERVOLT;
         end
      end
      sum = state_next.summary;
      bcode = sum[SUM_CODE_HI:SUM_CODE_LO];
      // First fault wins; a later one does not overwrite the code
      if (bcode == BFLT_NONE) begin
         sum[SUM_CODE_HI:SUM_CODE_LO] = bnew;
      end
      if (good_ev != BYTE_ZERO) begin
         sum[SUM_GOOD] = 1'b1;
      end
      if (ovl_ev != BYTE_ZERO) begin
         sum[SUM_OVL] = 1'b1;
      end
      if (clear_ok && fault_event.die_hot) begin
         sum[SUM_HOT] = 1'b1;
      end
      if (clear_ok && fault_event.input_overcurrent) begin
         sum[SUM_IN_OC] = 1'b1;
      end
      if (clear_ok && fault_event.input_overvoltage) begin
         sum[SUM_IN_OV] = 1'b1;
      end
      state_next.summary = sum;
      state_next.overload = state_next.overload | ovl_ev;
      state_next.good = state_next.good & ~good_ev;

      // Fault shutdown
      if (((good_ev | ovl_ev) & CORE_MASK) != BYTE_ZERO) begin
         state_next.core_trip = 1'b1;
      end
      iso_trip = good_ev & ISOLATE_MASK;
      iso_trip[RAIL_BOOST] = bnew != BFLT_NONE;
      state_next.trip = state_next.trip | iso_trip;

      // Regulator drive; default rails follow power-on, so after reset they start while it is high
      state_next.run = state_next.core_trip ? BYTE_ZERO
                       : (eff_en & valid_sp & ~state_next.trip);
      state_next.restart = rise;
      state_next.alert = state_next.summary != SUMMARY_RST;
      state_next.target_mv = boost_valid
         ? 16'(BOOST_CODE1_MV - BOOST_STEP_MV
               + 16'({10'h000, state_reg.setpoint[CODE_MSB:0]}) * BOOST_STEP_MV)
         : 16'h0000;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg.setpoint <= SETPOINT_RST;
         state_reg.clear <= CLEAR_RST;
         state_reg.summary <= SUMMARY_RST;
         state_reg.overload <= OVERLOAD_RST;
         state_reg.good <= GOOD_RST;
         state_reg.trip <= BYTE_ZERO;
         state_reg.core_trip <= 1'b0;
         state_reg.power_on_q <= 1'b0;
         state_reg.enable_q <= BYTE_ZERO;
         state_reg.run <= BYTE_ZERO;
         state_reg.restart <= BYTE_ZERO;
         state_reg.alert <= 1'b0;
         state_reg.rdata <= BYTE_ZERO;
         state_reg.target_mv <= 16'h0000;
      end else begin
         state_reg <= state_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign bus_rdata = state_reg.rdata;
   // Open-drain alert: pin only ever pulled low, released otherwise
   assign fault_alert_n_out = 1'b0;
   assign fault_alert_oe_b = ~state_reg.alert;
   assign rail_run = state_reg.run;
   assign rail_restart = state_reg.restart;
   assign boost_target_mv = state_reg.target_mv;

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_lock_sticky;
      @(posedge clk) disable iff (!rst_b)
      state_reg.setpoint[LOCK_BIT] |=> state_reg.setpoint[LOCK_BIT];
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit fell");

   property p_lock_set;
      @(posedge clk) disable iff (!rst_b)
      (bus_req.wr && bus_req.addr == ADDR_SETPOINT && !state_reg.setpoint[LOCK_BIT]
       && bus_req.wdata[CODE_MSB:0] != CODE_ZERO)
      |=> state_reg.setpoint[LOCK_BIT]
          && state_reg.setpoint[CODE_MSB:0] == $past(bus_req.wdata[CODE_MSB:0]);
   endproperty
   a_lock_set: assert property (p_lock_set) else $error("first write did not lock");

   property p_locked_write;
      @(posedge clk) disable iff (!rst_b)
      (bus_req.wr && bus_req.addr == ADDR_SETPOINT && state_reg.setpoint[LOCK_BIT])
      |=> $stable(state_reg.setpoint);
   endproperty
   a_locked_write: assert property (p_locked_write) else $error("locked code changed");

   property p_boost_run;
      @(posedge clk) disable iff (!rst_b)
      rail_run[RAIL_BOOST] |-> $past(rail_enable[RAIL_BOOST]) && boost_valid;
   endproperty
   a_boost_run: assert property (p_boost_run) else $error("boost ran without enable");

   property p_alert_cause;
      @(posedge clk) disable iff (!rst_b)
      !fault_alert_oe_b |-> state_reg.summary != SUMMARY_RST;
   endproperty
   a_alert_cause: assert property (p_alert_cause) else $error("alert without fault");

   property p_clear_cmd;
      @(posedge clk) disable iff (!rst_b)
      (state_reg.clear == CLEAR_CMD) ##1 (state_reg.clear == CLEAR_CMD)
      |-> state_reg.summary == SUMMARY_RST && state_reg.overload == OVERLOAD_RST
          && state_reg.good == GOOD_RST && fault_alert_oe_b;
   endproperty
   a_clear_cmd: assert property (p_clear_cmd) else $error("clear did not clear");

   property p_core_trip;
      @(posedge clk) disable iff (!rst_b)
      ((good_ev | ovl_ev) & CORE_MASK) != BYTE_ZERO
      |=> rail_run == BYTE_ZERO && !fault_alert_oe_b;
   endproperty
   a_core_trip: assert property (p_core_trip) else $error("core fault left rails on");

   property p_power_on_rise;
      @(posedge clk) disable iff (!rst_b)
      $rose(default_rails_power_on) && fault_event == '0
      |=> (rail_restart & DEFAULT_MASK) == DEFAULT_MASK && fault_alert_oe_b
          && state_reg.good == GOOD_RST;
   endproperty
   a_power_on_rise: assert property (p_power_on_rise) else $error("no default restart");

   property p_read_back;
      @(posedge clk) disable iff (!rst_b)
      (bus_req.rd && bus_req.addr == ADDR_SUMMARY) |=> bus_rdata == $past(state_reg.summary);
   endproperty
   a_read_back: assert property (p_read_back) else $error("read data wrong");

   property p_target;
      @(posedge clk) disable iff (!rst_b)
      state_reg.setpoint[CODE_MSB:1] == 5'h00
      |=> boost_target_mv == ($past(state_reg.setpoint[0]) ? BOOST_CODE1_MV : 16'h0000);
   endproperty
   a_target: assert property (p_target) else $error("boost target wrong");

endmodule

// ### verif/host_bus_model.sv
// Host side of the register port: byte-wide write and read cycles.
// Assumes one clock; the bench calls these tasks only after reset release.
module host_bus_model
   import boost_fault_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] bus_rdata,
   output reg_req_type bus_req
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      bus_req = '0;
   end

   // ************************************************************
   // Bus cycles
   // ************************************************************
   // One-cycle strobe beside address and data
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk);
      bus_req.addr <= addr;
      bus_req.wdata <= data;
      bus_req.wr <= 1'b1;
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask

   // Data stand only in the cycle after the strobe is taken
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clk);
      bus_req.addr <= addr;
      bus_req.rd <= 1'b1;
      @(posedge clk);
      bus_req.rd <= 1'b0;
      #1;
      data = bus_rdata;
      // Hand back on an edge so callers drive on the edge
      @(posedge clk);
   endtask

   // Clear command is always the pair 01h then 00h
   task automatic clear_faults();
      write_reg(ADDR_CLEAR, CLEAR_CMD);
      write_reg(ADDR_CLEAR, CLEAR_ARMED);
   endtask
endmodule

// ### verif/boost_setpoint_and_fault_regs_test.sv
// Self-checking bench for the boost setpoint and fault registers.
// Assumes shortened good-fault delays; the host model drives the register port.
module boost_setpoint_and_fault_regs_test
   import boost_fault_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk;
   logic rst_b;
   reg_req_type bus_req;
   logic [7:0] bus_rdata;
   logic power_on;
   logic [7:0] rail_enable;
   logic current_mode;
   logic adj_valid;
   fault_event_type ev;
   logic alert_n_out;
   logic alert_oe_b;
   logic alert_pin;
   logic [7:0] rail_run;
   logic [7:0] rail_restart;
   logic [15:0] target_mv;
   logic [7:0] rd;
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;

   // Pulled-up open-drain alert line
   assign alert_pin = alert_oe_b ? 1'b1 : alert_n_out;

   boost_setpoint_and_fault_regs #(.GOOD_DELAY_CYCLES(4), .SWITCH_DELAY_CYCLES(8)) uut (
      .clk(clk),
      .rst_b(rst_b),
      .bus_req(bus_req),
      .bus_rdata(bus_rdata),
      .default_rails_power_on(power_on),
      .rail_enable(rail_enable),
      .adj_setpoint_valid(adj_valid),
      .boost_current_mode(current_mode),
      .soft_start_done(8'hff),
      .fault_event(ev),
      .fault_alert_n_in(alert_pin),
      .fault_alert_n_out(alert_n_out),
      .fault_alert_oe_b(alert_oe_b),
      .rail_run(rail_run),
      .rail_restart(rail_restart),
      .boost_target_mv(target_mv)
   );

   host_bus_model u_host (
      .clk(clk),
      .bus_rdata(bus_rdata),
      .bus_req(bus_req)
   );

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
      u_host.read_reg(addr, rd);
      check($sformatf("reg %h", addr), {8'h00, rd}, {8'h00, exp});
   endtask

   task automatic pulse_event(input fault_event_type e);
      @(posedge clk);
      ev <= e;
      repeat (2) @(posedge clk);
      ev <= '0;
      repeat (2) @(posedge clk);
   endtask

   task automatic power_toggle();
      @(posedge clk);
      power_on <= 1'b0;
      repeat (2) @(posedge clk);
      power_on <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   task automatic print_verdict();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ************************************************************
   // Clock, reset, timeout
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         print_verdict();
      end
   end

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      fault_event_type e;
      rst_b = 1'b0;
      power_on = 1'b0;
      rail_enable = 8'h00;
      current_mode = 1'b0;
      adj_valid = 1'b0;
      ev = '0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      check_reg(ADDR_SETPOINT, 8'h00);
      check_reg(ADDR_SUMMARY, 8'h00);
      check_reg(ADDR_OVERLOAD, 8'h00);
      check_reg(ADDR_GOOD, 8'h11);
      check_reg(ADDR_CLEAR, 8'h00);
      check_reg(8'h20, 8'h00);
      check("run standby", {8'h00, rail_run}, 16'h0000);
      @(posedge clk);
      power_on <= 1'b1;
      repeat (3) @(posedge clk);
      check("run default", {8'h00, rail_run & DEFAULT_MASK}, 16'h003c);
      // Boost enabled over a zero code stays off and quiet
      rail_enable <= 8'h80;
      e = '0;
      e.boost_diode_open = 1'b1;
      pulse_event(e);
      check("boost off", {15'h0000, rail_run[7]}, 16'h0000);
      check("alert quiet", {15'h0000, alert_pin}, 16'h0001);
      check_reg(ADDR_SUMMARY, 8'h00);
      u_host.write_reg(ADDR_SETPOINT, 8'h05);
      check_reg(ADDR_SETPOINT, 8'h85);
      u_host.write_reg(ADDR_SETPOINT, 8'h0a);
      check_reg(ADDR_SETPOINT, 8'h85);
      check("target", target_mv, 16'h3264);
      check("boost on", {15'h0000, rail_run[7]}, 16'h0001);
      // Core overload trips everything
      e = '0;
      e.rail_overload[2] = 1'b1;
      pulse_event(e);
      check("alert core", {15'h0000, alert_pin}, 16'h0000);
      check("run tripped", {8'h00, rail_run}, 16'h0000);
      check_reg(ADDR_SUMMARY, 8'h10);
      check_reg(ADDR_OVERLOAD, 8'h04);
      u_host.clear_faults();
      check_reg(ADDR_SUMMARY, 8'h00);
      check_reg(ADDR_OVERLOAD, 8'h00);
      check("alert freed", {15'h0000, alert_pin}, 16'h0001);
      // Clear register not 00h: detection disarmed
      u_host.write_reg(ADDR_CLEAR, CLEAR_CMD);
      e = '0;
      e.die_hot = 1'b1;
      pulse_event(e);
      u_host.write_reg(ADDR_CLEAR, CLEAR_ARMED);
      check_reg(ADDR_SUMMARY, 8'h00);
      power_toggle();
      check("run restart", {8'h00, rail_run & DEFAULT_MASK}, 16'h003c);
      // Status-only flags land in their bit positions
      e = '0;
      e.die_hot = 1'b1;
      e.input_overcurrent = 1'b1;
      e.input_overvoltage = 1'b1;
      pulse_event(e);
      check_reg(ADDR_SUMMARY, 8'h0b);
      u_host.clear_faults();
      // Output-good fault on the 3V3 rail; rearmed good checks wait out their delay
      repeat (6) @(posedge clk);
      e = '0;
      e.rail_good_fail[4] = 1'b1;
      pulse_event(e);
      check_reg(ADDR_GOOD, 8'h01);
      check_reg(ADDR_SUMMARY, 8'h20);
      power_toggle();
      check_reg(ADDR_GOOD, 8'h11);
      check("alert after power", {15'h0000, alert_pin}, 16'h0001);
      // Each boost fault code isolates only the boost rail
      current_mode <= 1'b1;
      for (int code = 1; code < 4; code++) begin
         e = '0;
         e.boost_overvolt = (code == 1);
         e.boost_diode_open = (code == 2);
         e.boost_sink_short = (code == 3);
         pulse_event(e);
         check_reg(ADDR_SUMMARY, 8'(code << 6));
         check("boost isolated", {8'h00, rail_run & 8'hbc}, 16'h003c);
         check("alert boost", {15'h0000, alert_pin}, 16'h0000);
         rail_enable <= 8'h00;
         repeat (2) @(posedge clk);
         rail_enable <= 8'h80;
         repeat (3) @(posedge clk);
         check_reg(ADDR_SUMMARY, 8'h00);
         check("boost back", {15'h0000, rail_run[7]}, 16'h0001);
      end
      // Power cycle with power-on held high: lock drops, default rails start
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      check("restart pulse", {8'h00, rail_restart & DEFAULT_MASK}, 16'h003c);
      repeat (2) @(posedge clk);
      check("run after cycle", {8'h00, rail_run & DEFAULT_MASK}, 16'h003c);
      check_reg(ADDR_SETPOINT, 8'h00);
      // Adjustable rail needs its setpoint as well as its enable
      rail_enable <= 8'h40;
      repeat (3) @(posedge clk);
      check("adj no setpoint", {15'h0000, rail_run[6]}, 16'h0000);
      adj_valid <= 1'b1;
      repeat (2) @(posedge clk);
      check("adj on", {15'h0000, rail_run[6]}, 16'h0001);
      print_verdict();
   end
endmodule
